// ==== src/dpp_pkg.sv ====
// constants and decode helpers shared by the dual parallel port block
`default_nettype none
package dpp_pkg;
  // register indices carried on the two select lines
  localparam logic [1:0] DPP_IDX_DATA_A = 2'h0;
  localparam logic [1:0] DPP_IDX_CTRL_A = 2'h1;
  localparam logic [1:0] DPP_IDX_DATA_B = 2'h2;
  localparam logic [1:0] DPP_IDX_CTRL_B = 2'h3;
  localparam int         DPP_BYTE_STEP  = 4;
  localparam int         DPP_ADDR_W     = 8;
  localparam int         DPP_SEL_LSB    = 2;
  localparam int         DPP_MAP_TOP    = 4;
  // control register fields
  localparam int         DPP_CR_C1_EN    = 0;
  localparam int         DPP_CR_C1_EDGE  = 1;
  localparam int         DPP_CR_ACCESS   = 2;
  localparam int         DPP_CR_C2_B3    = 3;
  localparam int         DPP_CR_C2_EDGE  = 4;
  localparam int         DPP_CR_C2_OUT   = 5;
  localparam int         DPP_CR_FLAG2    = 6;
  localparam int         DPP_CR_FLAG1    = 7;
  localparam logic [7:0] DPP_CR_WR_MASK  = 8'h3f;
  localparam logic [7:0] DPP_REG_RESET   = 8'h00;
  localparam logic       DPP_CTL2_RESET  = 1'b1;
  // control line two output modes, bits 5..3
  localparam logic [2:0] DPP_C2_HANDSHAKE = 3'h4;
  localparam logic [2:0] DPP_C2_PULSE     = 3'h5;
  localparam logic [1:0] DPP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DPP_RESP_SLVERR = 2'h2;

  function automatic logic dpp_port_of(input logic [1:0] sel);
    return sel[1];
  endfunction

  function automatic logic dpp_is_ctrl(input logic [1:0] sel);
    return sel[0];
  endfunction
endpackage
`default_nettype wire

// ==== src/dpp_reg_if.sv ====
// request and answer path between the bus front end and the port core
`timescale 1ns/1ps
`default_nettype none
interface dpp_reg_if;
  logic       req;
  logic       wr;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  modport master (output req, output wr, output sel, output wdata, input ack, input rdata);
  modport slave  (input req, input wr, input sel, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

// ==== src/dpp_axil_slave.sv ====
// axi4-lite slave that turns bus transfers into single register requests
`timescale 1ns/1ps
`default_nettype none
module dpp_axil_slave
  import dpp_pkg::*;
(
  input  wire logic                      clk_sys,        // system clock
  input  wire logic                      reset_n,        // async reset, low
  input  wire logic [dpp_pkg::DPP_ADDR_W-1:0] s_axi_awaddr, // write address
  input  wire logic                      s_axi_awvalid,  // write address valid
  output logic                           s_axi_awready,  // write address ready
  input  wire logic [31:0]               s_axi_wdata,    // write data
  input  wire logic [3:0]                s_axi_wstrb,    // byte enables
  input  wire logic                      s_axi_wvalid,   // write data valid
  output logic                           s_axi_wready,   // write data ready
  output logic [1:0]                     s_axi_bresp,    // write response
  output logic                           s_axi_bvalid,   // write response valid
  input  wire logic                      s_axi_bready,   // write response ready
  input  wire logic [dpp_pkg::DPP_ADDR_W-1:0] s_axi_araddr, // read address
  input  wire logic                      s_axi_arvalid,  // read address valid
  output logic                           s_axi_arready,  // read address ready
  output logic [31:0]                    s_axi_rdata,    // read data
  output logic [1:0]                     s_axi_rresp,    // read response
  output logic                           s_axi_rvalid,   // read data valid
  input  wire logic                      s_axi_rready,   // read data ready
  dpp_reg_if.master                      core            // register requests
);
  logic                  aw_hold_q, w_hold_q, ar_hold_q, wait_q, wait_wr_q, wstrb0_q;
  logic [DPP_ADDR_W-1:0] awaddr_q, araddr_q;
  logic [7:0]            wdata_q;
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire wr_pend  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire rd_pend  = ar_hold_q & ~s_axi_rvalid;
  // reads go first; only one request is ever inside the core
  wire pick_rd  = ~wait_q & rd_pend;
  wire pick_wr  = ~wait_q & ~rd_pend & wr_pend;
  wire rd_map   = araddr_q[DPP_ADDR_W-1:DPP_MAP_TOP] == '0;
  wire wr_map   = awaddr_q[DPP_ADDR_W-1:DPP_MAP_TOP] == '0;
  // data lives in byte lane 0; a write without it is answered but dropped
  wire wr_eff   = wr_map & wstrb0_q;
  wire rd_done  = (pick_rd & ~rd_map) | (wait_q & ~wait_wr_q & core.ack);
  wire wr_done  = (pick_wr & ~wr_eff) | (wait_q & wait_wr_q & core.ack);
  wire aw_hold_d = aw_take | (aw_hold_q & ~wr_done);
  wire w_hold_d  = w_take | (w_hold_q & ~wr_done);
  wire ar_hold_d = ar_take | (ar_hold_q & ~rd_done);
  wire bvalid_d  = wr_done | (s_axi_bvalid & ~s_axi_bready);
  wire rvalid_d  = rd_done | (s_axi_rvalid & ~s_axi_rready);

  assign core.req   = (pick_rd & rd_map) | (pick_wr & wr_eff);
  assign core.wr    = pick_wr;
  assign core.sel   = pick_rd ? araddr_q[DPP_SEL_LSB +: 2] : awaddr_q[DPP_SEL_LSB +: 2];
  assign core.wdata = wdata_q;

  // ==========================================================
  // channel state
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {aw_hold_q, w_hold_q, ar_hold_q, wait_q, wait_wr_q, wstrb0_q} <= '0;
      {s_axi_awready, s_axi_wready, s_axi_arready} <= '0;
      {s_axi_bvalid, s_axi_rvalid} <= '0;
      awaddr_q <= '0;
      araddr_q <= '0;
      wdata_q  <= '0;
    end
    else
    begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      ar_hold_q     <= ar_hold_d;
      s_axi_awready <= ~aw_hold_d & ~bvalid_d;
      s_axi_wready  <= ~w_hold_d & ~bvalid_d;
      s_axi_arready <= ~ar_hold_d & ~rvalid_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_rvalid  <= rvalid_d;
      wait_q        <= core.req | (wait_q & ~core.ack);
      if (core.req) wait_wr_q <= core.wr;
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (ar_take) araddr_q <= s_axi_araddr;
      if (w_take)
      begin
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // ==========================================================
  // answers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bresp <= DPP_RESP_OKAY;
      s_axi_rresp <= DPP_RESP_OKAY;
      s_axi_rdata <= '0;
    end
    else
    begin
      if (wr_done) s_axi_bresp <= wr_map ? DPP_RESP_OKAY : DPP_RESP_SLVERR;
      if (rd_done)
      begin
        s_axi_rresp <= rd_map ? DPP_RESP_OKAY : DPP_RESP_SLVERR;
        s_axi_rdata <= rd_map ? {24'h000000, core.rdata} : 32'h00000000;
      end
    end
  end
endmodule // dpp_axil_slave
`default_nettype wire

// ==== src/dpp_top.sv ====
// two 8-bit peripheral ports with direction, output and control registers
`timescale 1ns/1ps
`default_nettype none
module dpp_top
  import dpp_pkg::*;
(
  input  wire logic                      clk_sys,          // 200 MHz system clock
  input  wire logic                      reset_n,          // async reset, low
  input  wire logic [dpp_pkg::DPP_ADDR_W-1:0] s_axi_awaddr, // write address
  input  wire logic                      s_axi_awvalid,    // write address valid
  output logic                           s_axi_awready,    // write address ready
  input  wire logic [31:0]               s_axi_wdata,      // write data
  input  wire logic [3:0]                s_axi_wstrb,      // byte enables
  input  wire logic                      s_axi_wvalid,     // write data valid
  output logic                           s_axi_wready,     // write data ready
  output logic [1:0]                     s_axi_bresp,      // write response
  output logic                           s_axi_bvalid,     // write response valid
  input  wire logic                      s_axi_bready,     // write response ready
  input  wire logic [dpp_pkg::DPP_ADDR_W-1:0] s_axi_araddr, // read address
  input  wire logic                      s_axi_arvalid,    // read address valid
  output logic                           s_axi_arready,    // read address ready
  output logic [31:0]                    s_axi_rdata,      // read data
  output logic [1:0]                     s_axi_rresp,      // read response
  output logic                           s_axi_rvalid,     // read data valid
  input  wire logic                      s_axi_rready,     // read data ready
  input  wire logic [7:0]                port_a_lines_i,   // port A pin levels
  output logic [7:0]                     port_a_lines_o,   // port A drive value
  output logic [7:0]                     port_a_lines_oe,  // port A drive enable
  input  wire logic [7:0]                port_b_lines_i,   // port B pin levels
  output logic [7:0]                     port_b_lines_o,   // port B drive value
  output logic [7:0]                     port_b_lines_oe,  // port B drive enable
  input  wire logic                      side_a_ctl_in,    // A control input
  input  wire logic                      side_a_ctl_io_i,  // A control line level
  output logic                           side_a_ctl_io_o,  // A control drive value
  output logic                           side_a_ctl_io_oe, // A control drive enable
  input  wire logic                      side_b_ctl_in,    // B control input
  input  wire logic                      side_b_ctl_io_i,  // B control line level
  output logic                           side_b_ctl_io_o,  // B control drive value
  output logic                           side_b_ctl_io_oe  // B control drive enable
);
  dpp_reg_if rif ();

  dpp_axil_slave u_bus (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .core          (rif.master)
  );

  // ==========================================================
  // write holding stage and answer
  logic       commit_q, ack_q;
  logic [1:0] sel_q;
  logic [7:0] din_q, rdata_q;
  // per port views, index 0 is A and 1 is B
  logic [7:0] dir_w  [2];
  logic [7:0] ctrl_w [2];
  logic [7:0] view_w [2];
  logic [7:0] raw_in [2];
  logic       c1_raw [2];
  logic       c2_raw [2];
  logic       c2_o_w [2];

  assign raw_in[0] = port_a_lines_i;
  assign raw_in[1] = port_b_lines_i;
  assign c1_raw[0] = side_a_ctl_in;
  assign c1_raw[1] = side_b_ctl_in;
  assign c2_raw[0] = side_a_ctl_io_i;
  assign c2_raw[1] = side_b_ctl_io_i;

  wire rd_req = rif.req & ~rif.wr;
  // the select lines and the access bit together name the register
  wire       rd_port   = dpp_port_of(rif.sel);
  wire [7:0] rd_mux    = dpp_is_ctrl(rif.sel) ? ctrl_w[rd_port] : view_w[rd_port];
  wire       cm_port   = dpp_port_of(sel_q);
  wire       cm_ctrl   = dpp_is_ctrl(sel_q);

  // data is held one cycle before it lands, so pins change once
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      commit_q <= 1'b0;
      ack_q    <= 1'b0;
      sel_q    <= DPP_IDX_DATA_A;
      din_q    <= DPP_REG_RESET;
      rdata_q  <= DPP_REG_RESET;
    end
    else
    begin
      commit_q <= rif.req & rif.wr;
      ack_q    <= rd_req | commit_q;
      if (rif.req & rif.wr)
      begin
        sel_q <= rif.sel;
        din_q <= rif.wdata;
      end
      if (rd_req) rdata_q <= rd_mux;
    end
  end

  assign rif.ack   = ack_q;
  assign rif.rdata = rdata_q;

  // ==========================================================
  // one port slice per side
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    logic [7:0] dir_q, out_q, ctrl_q, pin_s1, pin_s2;
    logic [2:0] c1_s, c2_s;
    logic       c2_out_q;
    wire access = ctrl_q[DPP_CR_ACCESS];
    wire mine   = cm_port == 1'(p);
    wire rd_hit = rd_req & (dpp_port_of(rif.sel) == 1'(p)) & ~dpp_is_ctrl(rif.sel);
    wire rd_dat = rd_hit & access;
    wire wr_dat = commit_q & mine & ~cm_ctrl & access;
    wire wr_dir = commit_q & mine & ~cm_ctrl & ~access;
    wire wr_ctl = commit_q & mine & cm_ctrl;
    // only the second stage and the history flop feed edge logic
    wire c1_act = ctrl_q[DPP_CR_C1_EDGE] ? (c1_s[1] & ~c1_s[2]) : (~c1_s[1] & c1_s[2]);
    wire c2_edg = ctrl_q[DPP_CR_C2_EDGE] ? (c2_s[1] & ~c2_s[2]) : (~c2_s[1] & c2_s[2]);
    wire c2_act = ~ctrl_q[DPP_CR_C2_OUT] & c2_edg;
    // A handshakes on reads of its data, B on writes
    wire evt    = (p == 0) ? rd_dat : wr_dat;
    wire [2:0] mode = ctrl_q[DPP_CR_C2_OUT:DPP_CR_C2_B3];

    // flags are cleared by a data read but a same-cycle edge still sets them
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
      begin
        dir_q  <= DPP_REG_RESET;
        out_q  <= DPP_REG_RESET;
        ctrl_q <= DPP_REG_RESET;
      end
      else
      begin
        if (wr_dir) dir_q <= din_q;
        if (wr_dat) out_q <= din_q;
        if (wr_ctl) ctrl_q[DPP_CR_C2_OUT:0] <= din_q[DPP_CR_C2_OUT:0];
        ctrl_q[DPP_CR_FLAG1] <= c1_act | (ctrl_q[DPP_CR_FLAG1] & ~rd_dat);
        ctrl_q[DPP_CR_FLAG2] <= c2_act | (ctrl_q[DPP_CR_FLAG2] & ~rd_dat);
      end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
      begin
        pin_s1 <= '0;
        pin_s2 <= '0;
        c1_s   <= '0;
        c2_s   <= '0;
      end
      else
      begin
        pin_s1 <= raw_in[p];
        pin_s2 <= pin_s1;
        c1_s   <= {c1_s[1:0], c1_raw[p]};
        c2_s   <= {c2_s[1:0], c2_raw[p]};
      end
    end

    // control line two drive value
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        c2_out_q <= DPP_CTL2_RESET;
      else if (mode == DPP_C2_HANDSHAKE)
        c2_out_q <= c1_act | (c2_out_q & ~evt);
      else if (mode == DPP_C2_PULSE)
        c2_out_q <= ~evt;
      else if (ctrl_q[DPP_CR_C2_EDGE])
        c2_out_q <= ctrl_q[DPP_CR_C2_B3];
      else
        c2_out_q <= DPP_CTL2_RESET;
    end

    assign dir_w[p]  = dir_q;
    assign ctrl_w[p] = ctrl_q;
    assign c2_o_w[p] = c2_out_q;
    // A reads pins everywhere; B reads its register on output lines
    if (p == 0)
    begin : g_view_a
      assign view_w[p] = access ? pin_s2 : dir_q;
    end
    else
    begin : g_view_b
      assign view_w[p] = access ? ((out_q & dir_q) | (pin_s2 & ~dir_q)) : dir_q;
    end
  end

  // ==========================================================
  // pins, all straight from flops
  assign port_a_lines_o   = g_port[0].out_q;
  assign port_a_lines_oe  = dir_w[0];
  assign port_b_lines_o   = g_port[1].out_q;
  assign port_b_lines_oe  = dir_w[1];
  assign side_a_ctl_io_o  = c2_o_w[0];
  assign side_a_ctl_io_oe = ctrl_w[0][DPP_CR_C2_OUT];
  assign side_b_ctl_io_o  = c2_o_w[1];
  assign side_b_ctl_io_oe = ctrl_w[1][DPP_CR_C2_OUT];
endmodule // dpp_top
`default_nettype wire

// ==== verification/dpp_top_sva.sv ====
// concurrent checks on the ports of the dual parallel port top
`timescale 1ns/1ps
`default_nettype none
module dpp_chk
  import dpp_pkg::*;
(
  input wire logic                            clk_sys,         // clock
  input wire logic                            reset_n,         // reset, low
  input wire logic [dpp_pkg::DPP_ADDR_W-1:0] s_axi_awaddr,    // aw address
  input wire logic                            s_axi_awvalid,   // aw valid
  input wire logic                            s_axi_awready,   // aw ready
  input wire logic [3:0]                      s_axi_wstrb,     // strobes
  input wire logic                            s_axi_wvalid,    // w valid
  input wire logic                            s_axi_wready,    // w ready
  input wire logic [1:0]                      s_axi_bresp,     // b response
  input wire logic                            s_axi_bvalid,    // b valid
  input wire logic [dpp_pkg::DPP_ADDR_W-1:0] s_axi_araddr,    // ar address
  input wire logic                            s_axi_arvalid,   // ar valid
  input wire logic                            s_axi_arready,   // ar ready
  input wire logic [31:0]                     s_axi_rdata,     // read data
  input wire logic [1:0]                      s_axi_rresp,     // r response
  input wire logic                            s_axi_rvalid,    // r valid
  input wire logic                            s_axi_rready,    // r ready
  input wire logic [7:0]                      port_a_lines_o,  // A drive
  input wire logic [7:0]                      port_a_lines_oe, // A enable
  input wire logic [7:0]                      port_b_lines_o,  // B drive
  input wire logic [7:0]                      port_b_lines_oe  // B enable
);
  // =======
  // handshakes
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire aw_hs  = s_axi_awvalid && s_axi_awready;
  wire w_hs   = s_axi_wvalid && s_axi_wready;
  wire ar_hs  = s_axi_arvalid && s_axi_arready;
  wire aw_bad = s_axi_awaddr[7:4] != 4'h0;
  wire ar_bad = s_axi_araddr[7:4] != 4'h0;
  wire [31:0] pins = {port_a_lines_o, port_a_lines_oe, port_b_lines_o, port_b_lines_oe};
  sequence s_read_ok;
    ##3 s_axi_rvalid && s_axi_rresp == DPP_RESP_OKAY;
  endsequence
  sequence s_write_ok;
    ##4 s_axi_bvalid && s_axi_bresp == DPP_RESP_OKAY;
  endsequence
  // =======
  // properties
  a_reset_clear: assert property ($rose(reset_n) |-> pins == 32'h0)
    else $error("port outputs not cleared by reset");
  a_read_map: assert property (ar_hs && !ar_bad |-> s_read_ok)
    else $error("mapped read answer late or not okay");
  a_read_unmap: assert property (ar_hs && ar_bad |-> ##[2:3] (s_axi_rvalid
    && s_axi_rresp == DPP_RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("unmapped read not refused");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte lane nonzero");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");
  a_write_lat: assert property (aw_hs && w_hs && !aw_bad && s_axi_wstrb[0] |-> s_write_ok)
    else $error("write answer late or not okay");
  a_write_unmap: assert property (aw_hs && w_hs && aw_bad |-> ##2 (s_axi_bvalid
    && s_axi_bresp == DPP_RESP_SLVERR))
    else $error("unmapped write not refused");
  a_aw_busy: assert property (aw_hs |=> !s_axi_awready [*2])
    else $error("write address taken while busy");
  a_pin_commit: assert property ($changed(pins) |=> $rose(s_axi_bvalid))
    else $error("port outputs changed outside write commit");
endmodule // dpp_chk
bind dpp_top dpp_chk u_chk (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_lines_o, .port_a_lines_oe,
  .port_b_lines_o, .port_b_lines_oe);
`default_nettype wire

// ==== verification/dpp_periph.sv ====
// peripheral side model: drives input lines, may load output lines low
`timescale 1ns/1ps
`default_nettype none
module dpp_periph
(
  input wire logic [7:0] a_o,     // A drive
  input wire logic [7:0] a_oe,    // A enable
  input wire logic [7:0] a_ext,   // A far drive
  input wire logic [7:0] a_load,  // A clamp low
  output logic [7:0]     a_pin,   // A level
  input wire logic [7:0] b_o,     // B drive
  input wire logic [7:0] b_oe,    // B enable
  input wire logic [7:0] b_ext,   // B far drive
  input wire logic [7:0] b_load,  // B clamp low
  output logic [7:0]     b_pin,   // B level
  input wire logic       a_c2_o,  // A line two
  input wire logic       a_c2_oe, // A line two en
  output logic           a_c2,    // A line level
  input wire logic       b_c2_o,  // B line two
  input wire logic       b_c2_oe, // B line two en
  output logic           b_c2     // B line level
);
  // a heavy load pulls a driven high line low, as an external clamp would
  assign a_pin = (a_oe & a_o & ~a_load) | (~a_oe & a_ext);
  assign b_pin = (b_oe & b_o & ~b_load) | (~b_oe & b_ext);
  // control lines idle high through a pull-up when nobody drives
  assign a_c2 = a_c2_oe ? a_c2_o : 1'b1;
  assign b_c2 = b_c2_oe ? b_c2_o : 1'b1;
endmodule // dpp_periph
`default_nettype wire

// ==== verification/tb_dual_parallel_io_port_paths.sv ====
// self-checking bench for the dual parallel port top
`timescale 1ns/1ps
`default_nettype none
module tb_dual_parallel_io_port_paths;
  import dpp_pkg::*;
  logic        clk_sys, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  a_pin, a_o, a_oe, b_pin, b_o, b_oe, ext_a, ext_b, load_a, load_b;
  logic        a_c1, a_c2, a_c2_o, a_c2_oe, b_c1, b_c2, b_c2_o, b_c2_oe;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          lows = 0;
  dpp_top dut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_a_lines_i(a_pin), .port_a_lines_o(a_o), .port_a_lines_oe(a_oe),
    .port_b_lines_i(b_pin), .port_b_lines_o(b_o), .port_b_lines_oe(b_oe),
    .side_a_ctl_in(a_c1), .side_a_ctl_io_i(a_c2), .side_a_ctl_io_o(a_c2_o),
    .side_a_ctl_io_oe(a_c2_oe), .side_b_ctl_in(b_c1), .side_b_ctl_io_i(b_c2),
    .side_b_ctl_io_o(b_c2_o), .side_b_ctl_io_oe(b_c2_oe));
  dpp_periph u_per (.a_o, .a_oe, .a_ext(ext_a), .a_load(load_a), .a_pin, .b_o, .b_oe,
    .b_ext(ext_b), .b_load(load_b), .b_pin, .a_c2_o, .a_c2_oe, .a_c2, .b_c2_o,
    .b_c2_oe, .b_c2);
  // =======
  // clock, timeout, verdict
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      summarize();
    end
  end
  // cycles in which either control line two output sits low
  always @(posedge clk_sys)
    if (a_c2_o !== 1'b1 || b_c2_o !== 1'b1)
      lows++;
  // =======
  // bus tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_sys);
      aw_ok = aw_ok || (s_axi_awready === 1'b1);
      w_ok = w_ok || (s_axi_wready === 1'b1);
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    // bready stays high throughout, so the answer is taken where it is seen
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // rready raised late on purpose so the answer must stand
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("bresp", {6'h0, r}, {6'h0, DPP_RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [31:0] v;
    logic [1:0] r;
    axr(a, v, r);
    chk(what, v[7:0], e);
    chk("rresp", {6'h0, r}, {6'h0, DPP_RESP_OKAY});
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("oe_a_rst", a_oe, 8'h00);
    chk("oe_b_rst", b_oe, 8'h00);
    chk("o_a_rst", a_o | b_o, 8'h00);
    rd(8'h04, 8'h00, "ctrl_a_rst");
    rd(8'h0c, 8'h00, "ctrl_b_rst");
    rd(8'h00, 8'h00, "dir_a_rst");
    rd(8'h08, 8'h00, "dir_b_rst");
  endtask
  // =======
  // scenarios
  initial
  begin
    logic [1:0]  r2;
    logic [31:0] v;
    logic [7:0]  base;
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_bready = 1'b1;
    s_axi_wstrb = 4'h1;
    {ext_a, ext_b, load_a, load_b} = 32'h3cc3_800f;
    {a_c1, b_c1} = 2'h0;
    do_reset();
    wr(8'h00, 8'hf0);
    wr(8'h04, 8'h04);
    rd(8'h04, 8'h04, "ctrl_a");
    wr(8'h00, 8'ha5);
    chk("oe_a", a_oe, 8'hf0);
    chk("o_a", a_o, 8'ha5);
    rd(8'h00, 8'h2c, "data_a");
    wr(8'h04, 8'h00);
    rd(8'h00, 8'hf0, "dir_a");
    wr(8'h08, 8'h0f);
    wr(8'h0c, 8'h04);
    wr(8'h08, 8'h5a);
    chk("oe_b", b_oe, 8'h0f);
    chk("o_b", b_o, 8'h5a);
    rd(8'h08, 8'hca, "data_b");
    axw(8'h10, 8'hff, r2);
    chk("bresp_bad", {6'h0, r2}, {6'h0, DPP_RESP_SLVERR});
    axr(8'h30, v, r2);
    chk("rresp_bad", {6'h0, r2}, {6'h0, DPP_RESP_SLVERR});
    rd(8'h08, 8'hca, "data_b_kept");
    for (int i = 0; i < 2; i++)
    begin
      base = 8'(i * 8);
      wr(base + 8'h04, 8'hc6);
      rd(base + 8'h04, 8'h06, "ctrl_ro");
      if (i == 0)
        a_c1 <= 1'b1;
      else
        b_c1 <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd(base + 8'h04, 8'h86, "flag_set");
      rd(base, (i == 0) ? 8'h2c : 8'hca, "data_mix");
      rd(base + 8'h04, 8'h06, "flag_clr");
      wr(base + 8'h04, 8'h3c);
      chk("c2_oe", {7'h0, (i == 0) ? a_c2_oe : b_c2_oe}, 8'h01);
      chk("c2_high", {7'h0, (i == 0) ? a_c2_o : b_c2_o}, 8'h01);
      wr(base + 8'h04, 8'h34);
      chk("c2_low", {7'h0, (i == 0) ? a_c2_o : b_c2_o}, 8'h00);
      // handshake: line one edge raises line two, data access drops it
      wr(base + 8'h04, 8'h26);
      if (i == 0)
        a_c1 <= 1'b0;
      else
        b_c1 <= 1'b0;
      repeat (6) @(posedge clk_sys);
      if (i == 0)
        a_c1 <= 1'b1;
      else
        b_c1 <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("c2_hs_set", {7'h0, (i == 0) ? a_c2_o : b_c2_o}, 8'h01);
      if (i == 0)
        rd(base, 8'h2c, "data_hs");
      else
        wr(base, 8'h5a);
      chk("c2_hs_clr", {7'h0, (i == 0) ? a_c2_o : b_c2_o}, 8'h00);
      // pulse: exactly one low cycle per data access
      wr(base + 8'h04, 8'h2e);
      lows = 0;
      if (i == 0)
        rd(base, 8'h2c, "data_pulse");
      else
        wr(base, 8'h5a);
      chk("c2_pulse", 8'(lows), 8'h01);
      chk("c2_idle", {7'h0, (i == 0) ? a_c2_o : b_c2_o}, 8'h01);
    end
    {a_c1, b_c1} <= 2'h0;
    repeat (6) @(posedge clk_sys);
    do_reset();
    summarize();
  end
endmodule // tb_dual_parallel_io_port_paths
`default_nettype wire
